//--- design/aps_sequencer.sv
// Purpose: APB control of the fast RC oscillator, PLL, bandgap, ADC sequencing and analog selects; slow RC held running
// Assumes: adc_tick is one pclk pulse per ADC clock; trigger events are pclk pulses
// Notes: every APB transfer completes with no wait state; read data comes from a flop loaded in the setup cycle
`timescale 1ns/1ps
`default_nettype none
module aps_sequencer #(
   parameter int NUM_CH = 16,
   parameter int DATA_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic adc_tick,
   input wire logic [DATA_W-1:0] adc_data,
   input wire logic [3:0] trig_events,
   output logic slow_rc_run,
   output logic fast_rc_powerdown,
   output logic bandgap_powerdown,
   output logic ref_measure_enable,
   output logic pll_powerup,
   output logic [1:0] adc_clock_select,
   output logic [1:0] adc_bias_current_select,
   output logic adc_enable,
   output logic adc_sampling,
   output logic adc_converting,
   output logic [3:0] adc_channel,
   output logic adc_channel_gain_select,
   output logic [1:0] amp_powerup,
   output logic [1:0] amp_feedback_ratio,
   output logic [1:0] amp_output_route_select,
   output logic [1:0] comparator_powerup,
   output logic [1:0] comparator_hysteresis_select,
   output logic [5:0] comparator_plus_source,
   output logic [3:0] comparator_minus_source,
   output logic temp_sensor_powerup,
   output logic dac_powerup,
   output logic dac_pin_output_enable,
   output logic dac_full_scale_select
);
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic slow_rc;
      logic [aps_pkg::PW_W-1:0] pwr;
      logic [aps_pkg::CF_W-1:0] cfg;
      logic [aps_pkg::AN_W-1:0] ana;
      logic [NUM_CH-1:0] gain;
      logic gain_out;
      logic go;
      aps_pkg::aps_adc_state_type st;
      logic sampling;
      logic converting;
      logic [3:0] ch;
      logic [4:0] ticks;
      logic [3:0] trig_cnt;
      logic [7:0] bg_cnt;
      logic [7:0] pll_cnt;
      logic [7:0] tmp_cnt;
      logic [NUM_CH-1:0][DATA_W-1:0] result;
   } aps_state_type;

   localparam logic [7:0] BG_CYC = 8'(aps_pkg::BG_SETTLE_CYC);
   localparam logic [7:0] PLL_CYC = 8'(aps_pkg::PLL_SETTLE_CYC);
   localparam logic [7:0] TMP_CYC = 8'(aps_pkg::TEMP_SETTLE_CYC);

   // the channel index is four bits and the settle timers eight
   if (NUM_CH != 16 || DATA_W < 1 || DATA_W > 32 || aps_pkg::PLL_SETTLE_CYC > 255
         || aps_pkg::BG_SETTLE_CYC > 255 || aps_pkg::TEMP_SETTLE_CYC > 255) begin : g_bad_params
      $error("aps_sequencer: unsupported parameters");
   end

   aps_state_type r_reg;
   aps_state_type r_next;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            m[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return m;
   endfunction

   logic setup;
   logic access;
   logic bg_ready;
   logic pll_ready;
   logic tmp_ready;
   logic [1:0] mode;
   logic [4:0] samp_len;
   logic [3:0] trig_need;
   logic hw_fire;
   logic start;
   logic stop;
   logic go_set;
   logic [3:0] first_ch;
   logic [31:0] rd;
   logic rd_err;

   always_comb begin
      r_next = r_reg;
      setup = psel && !penable;
      access = psel && penable && r_reg.pready;
      bg_ready = r_reg.bg_cnt == BG_CYC;
      pll_ready = r_reg.pll_cnt == PLL_CYC;
      tmp_ready = r_reg.tmp_cnt == TMP_CYC;
      mode = r_reg.cfg[aps_pkg::CF_MODE +: 2];
      // sample field value v gives v plus four ADC clocks
      samp_len = 5'(r_reg.cfg[aps_pkg::CF_SAMP +: 4]) + aps_pkg::SAMPLE_BASE;
      trig_need = (r_reg.cfg[aps_pkg::CF_TRIG_CNT +: 4] == 4'h0) ? 4'h1 : r_reg.cfg[aps_pkg::CF_TRIG_CNT +: 4];
      hw_fire = 1'b0;
      first_ch = (mode[1]) ? 4'h0 : r_reg.cfg[aps_pkg::CF_SINGLE_CH +: 4];
      rd = 32'h0000_0000;
      rd_err = 1'b0;
      // apb: setup edge loads answer, access edge commits the write
      r_next.pready = setup;
      r_next.slow_rc = 1'b1;
      if (paddr == aps_pkg::OFS_POWER) begin
         rd = 32'(r_reg.pwr);
      end else if (paddr == aps_pkg::OFS_ADC_CFG) begin
         rd = 32'(r_reg.cfg);
      end else if (paddr == aps_pkg::OFS_ANALOG) begin
         rd = 32'(r_reg.ana);
      end else if (paddr == aps_pkg::OFS_GAIN) begin
         rd = 32'(r_reg.gain);
      end else if (paddr == aps_pkg::OFS_CTRL) begin
         rd = 32'(r_reg.go);
      end else if (paddr == aps_pkg::OFS_STATUS) begin
         rd = {20'h0_0000, r_reg.ch, (r_reg.st != aps_pkg::ST_IDLE), tmp_ready, pll_ready, bg_ready};
      end else if (paddr[11:6] == aps_pkg::OFS_RESULT[11:6]) begin
         rd = 32'(r_reg.result[paddr[5:2]]);
      end else begin
         rd_err = 1'b1;
      end
      if (setup) begin
         r_next.prdata = pwrite ? 32'h0000_0000 : rd;
         r_next.pslverr = rd_err;
      end
      stop = 1'b0;
      go_set = 1'b0;
      if (access && pwrite && !r_reg.pslverr) begin
         if (paddr == aps_pkg::OFS_POWER) begin
            r_next.pwr = aps_pkg::PW_W'(merge(32'(r_reg.pwr), pwdata, pstrb));
         end else if (paddr == aps_pkg::OFS_ADC_CFG) begin
            r_next.cfg = aps_pkg::CF_W'(merge(32'(r_reg.cfg), pwdata, pstrb));
         end else if (paddr == aps_pkg::OFS_ANALOG) begin
            r_next.ana = aps_pkg::AN_W'(merge(32'(r_reg.ana), pwdata, pstrb));
         end else if (paddr == aps_pkg::OFS_GAIN) begin
            r_next.gain = NUM_CH'(merge(32'(r_reg.gain), pwdata, pstrb));
         end else if (paddr == aps_pkg::OFS_CTRL && pstrb[0]) begin
            stop = pwdata[aps_pkg::CT_STOP];
            go_set = pwdata[aps_pkg::CT_GO];
            if (go_set) begin
               r_next.go = 1'b1;
            end
         end
      end
      // settle timers restart whenever the block is switched off
      // next power word, so a ready bit never outlives the switch-off edge
      r_next.bg_cnt = r_next.pwr[aps_pkg::PW_BG_PD] ? 8'h00 : (bg_ready ? BG_CYC : r_reg.bg_cnt + 8'h01);
      r_next.pll_cnt = !r_next.pwr[aps_pkg::PW_PLL_PU] ? 8'h00 : (pll_ready ? PLL_CYC : r_reg.pll_cnt + 8'h01);
      r_next.tmp_cnt = !r_next.pwr[aps_pkg::PW_TEMP_PU] ? 8'h00 : (tmp_ready ? TMP_CYC : r_reg.tmp_cnt + 8'h01);
      if (r_reg.cfg[aps_pkg::CF_TRIG_HW] && trig_events[r_reg.cfg[aps_pkg::CF_TRIG_SEL +: 2]]) begin
         if (r_reg.trig_cnt + 4'h1 >= trig_need) begin
            hw_fire = 1'b1;
            r_next.trig_cnt = 4'h0;
         end else begin
            r_next.trig_cnt = r_reg.trig_cnt + 4'h1;
         end
      end
      start = r_reg.pwr[aps_pkg::PW_ADC_EN] && r_reg.st == aps_pkg::ST_IDLE && (r_reg.go || hw_fire);
      // a go written in the start cycle stays pending: the set wins
      if (start && !go_set) begin
         r_next.go = 1'b0;
      end
      // disabling the adc or a stop request abandons the conversion
      if (!r_reg.pwr[aps_pkg::PW_ADC_EN] || stop) begin
         r_next.st = aps_pkg::ST_IDLE;
         r_next.go = 1'b0;
         r_next.ticks = 5'h00;
      end else begin
         case (r_reg.st)
            aps_pkg::ST_IDLE: begin
               if (start) begin
                  r_next.st = aps_pkg::ST_SAMPLE;
                  r_next.ch = first_ch;
                  r_next.ticks = 5'h00;
               end
            end
            aps_pkg::ST_SAMPLE: begin
               if (adc_tick) begin
                  if (r_reg.ticks == samp_len - 5'h01) begin
                     r_next.st = aps_pkg::ST_CONVERT;
                     r_next.ticks = 5'h00;
                  end else begin
                     r_next.ticks = r_reg.ticks + 5'h01;
                  end
               end
            end
            aps_pkg::ST_CONVERT: begin
               if (adc_tick) begin
                  if (r_reg.ticks == aps_pkg::CONV_CYC - 5'h01) begin
                     r_next.result[r_reg.ch] = adc_data;
                     r_next.ticks = 5'h00;
                     r_next.st = aps_pkg::ST_SAMPLE;
                     if (mode[1] && r_reg.ch != r_reg.cfg[aps_pkg::CF_SCAN_LAST +: 4]) begin
                        r_next.ch = r_reg.ch + 4'h1;
                     end else if (mode == aps_pkg::MODE_CONT_SINGLE || mode == aps_pkg::MODE_CONT_SCAN) begin
                        r_next.ch = first_ch;
                     end else begin
                        r_next.st = aps_pkg::ST_IDLE;
                     end
                  end else begin
                     r_next.ticks = r_reg.ticks + 5'h01;
                  end
               end
            end
            default: begin
               r_next.st = aps_pkg::ST_IDLE;
            end
         endcase
      end
      r_next.gain_out = r_next.gain[r_next.ch];
      r_next.sampling = r_next.st == aps_pkg::ST_SAMPLE;
      r_next.converting = r_next.st == aps_pkg::ST_CONVERT;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg <= '0;
         r_reg.slow_rc <= 1'b1;
         r_reg.pwr <= aps_pkg::PWR_RST;
         r_reg.cfg <= aps_pkg::CFG_RST;
         r_reg.ana <= aps_pkg::ANA_RST;
         r_reg.st <= aps_pkg::ST_IDLE;
      end else if (ce) begin
         r_reg <= r_next;
      end
   end

   assign prdata = r_reg.prdata;
   assign pready = r_reg.pready;
   assign pslverr = r_reg.pslverr;
   assign slow_rc_run = r_reg.slow_rc;
   assign fast_rc_powerdown = r_reg.pwr[aps_pkg::PW_RCH_PD];
   assign bandgap_powerdown = r_reg.pwr[aps_pkg::PW_BG_PD];
   assign ref_measure_enable = r_reg.pwr[aps_pkg::PW_REF_MEAS];
   assign pll_powerup = r_reg.pwr[aps_pkg::PW_PLL_PU];
   assign adc_clock_select = r_reg.cfg[aps_pkg::CF_CLKSEL +: 2];
   assign adc_bias_current_select = r_reg.cfg[aps_pkg::CF_BIAS +: 2];
   assign adc_enable = r_reg.pwr[aps_pkg::PW_ADC_EN];
   assign adc_sampling = r_reg.sampling;
   assign adc_converting = r_reg.converting;
   assign adc_channel = r_reg.ch;
   assign adc_channel_gain_select = r_reg.gain_out;
   assign amp_powerup = r_reg.pwr[aps_pkg::PW_AMP_PU +: 2];
   assign amp_feedback_ratio = r_reg.ana[aps_pkg::AN_FB +: 2];
   assign amp_output_route_select = r_reg.ana[aps_pkg::AN_ROUTE +: 2];
   assign comparator_powerup = r_reg.pwr[aps_pkg::PW_CMP_PU +: 2];
   assign temp_sensor_powerup = r_reg.pwr[aps_pkg::PW_TEMP_PU];
   assign dac_powerup = r_reg.pwr[aps_pkg::PW_DAC_PU];
   assign dac_pin_output_enable = r_reg.pwr[aps_pkg::PW_DAC_OE];
   assign dac_full_scale_select = r_reg.pwr[aps_pkg::PW_DAC_FS];

   for (genvar c = 0; c < 2; c++) begin : g_cmp
      localparam int B = aps_pkg::AN_CMP + c * aps_pkg::AN_CMP_W;
      assign comparator_hysteresis_select[c] = r_reg.ana[B];
      assign comparator_plus_source[c*3 +: 3] = r_reg.ana[B+1 +: 3];
      assign comparator_minus_source[c*2 +: 2] = r_reg.ana[B+4 +: 2];
   end

   // helper: adc ticks spent in the current conversion phase
   logic [4:0] conv_seen;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_seen <= 5'h00;
      end else if (ce) begin
         conv_seen <= adc_converting ? conv_seen + 5'(adc_tick) : 5'h00;
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_pll_needs_powerup: assert property (r_reg.pll_cnt != 8'h00 |-> pll_powerup) else $error("pll timer without powerup");
   chk_slow_rc_on: assert property (slow_rc_run) else $error("slow rc stopped");
   chk_bg_ready_on: assert property (bg_ready |-> !bandgap_powerdown) else $error("bandgap ready while off");
   // a stop abandons the conversion early, so it is left out
   chk_conv_twelve: assert property (ce && $fell(adc_converting) && adc_enable && !$past(stop) |-> $past(conv_seen) == 5'h0b)
      else $error("conversion length wrong");
   chk_single_chan: assert property (adc_sampling && !r_reg.cfg[aps_pkg::CF_MODE+1] && $rose(adc_sampling)
      |-> adc_channel == r_reg.cfg[aps_pkg::CF_SINGLE_CH +: 4]) else $error("wrong single channel");
   chk_sw_start: assert property (ce && r_reg.go && adc_enable && r_reg.st == aps_pkg::ST_IDLE ##1 ce
      |-> adc_sampling || !adc_enable) else $error("software trigger lost");
   chk_gain_route: assert property (adc_channel_gain_select == r_reg.gain[adc_channel]) else $error("gain mismatch");
   chk_apb_wait: assert property (ce && psel && !penable |=> pready) else $error("apb answer late");
endmodule
`default_nettype wire

//--- design/aps_pkg.sv
// Purpose: shared constants for the analog power and clock sequencer
// Assumes: 20 MHz pclk, APB register access with 32-bit data
// Notes: field positions index the control words held in the top module
package aps_pkg;
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned PLL_SETTLE_NS = 6000;
   localparam int unsigned BG_SETTLE_NS = 2000;
   localparam int unsigned TEMP_SETTLE_NS = 2000;
   // least times: round up to whole cycles
   localparam int unsigned PLL_SETTLE_CYC = (PLL_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned BG_SETTLE_CYC = (BG_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned TEMP_SETTLE_CYC = (TEMP_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [11:0] OFS_POWER = 12'h000;
   localparam logic [11:0] OFS_ADC_CFG = 12'h004;
   localparam logic [11:0] OFS_ANALOG = 12'h008;
   localparam logic [11:0] OFS_GAIN = 12'h00c;
   localparam logic [11:0] OFS_CTRL = 12'h010;
   localparam logic [11:0] OFS_STATUS = 12'h014;
   localparam logic [11:0] OFS_RESULT = 12'h040;
   // power word
   localparam int PW_RCH_PD = 0;
   localparam int PW_BG_PD = 1;
   localparam int PW_PLL_PU = 2;
   localparam int PW_REF_MEAS = 3;
   localparam int PW_TEMP_PU = 4;
   localparam int PW_ADC_EN = 5;
   localparam int PW_AMP_PU = 6;
   localparam int PW_CMP_PU = 8;
   localparam int PW_DAC_PU = 10;
   localparam int PW_DAC_OE = 11;
   localparam int PW_DAC_FS = 12;
   localparam int PW_W = 13;
   // adc configuration word
   localparam int CF_CLKSEL = 0;
   localparam int CF_SAMP = 2;
   localparam int CF_MODE = 6;
   localparam int CF_SCAN_LAST = 8;
   localparam int CF_SINGLE_CH = 12;
   localparam int CF_TRIG_SEL = 16;
   localparam int CF_TRIG_HW = 18;
   localparam int CF_TRIG_CNT = 20;
   localparam int CF_BIAS = 24;
   localparam int CF_W = 26;
   // analog word: two comparator slices of six bits each
   localparam int AN_FB = 0;
   localparam int AN_ROUTE = 2;
   localparam int AN_CMP = 4;
   localparam int AN_CMP_W = 6;
   localparam int AN_W = 16;
   localparam int CT_GO = 0;
   localparam int CT_STOP = 1;
   localparam logic [PW_W-1:0] PWR_RST = 13'h0000;
   localparam logic [CF_W-1:0] CFG_RST = 26'h000_0000;
   localparam logic [AN_W-1:0] ANA_RST = 16'h0000;
   localparam logic [4:0] SAMPLE_BASE = 5'h04;
   localparam logic [4:0] CONV_CYC = 5'h0c;
   localparam logic [1:0] MODE_ONE_SINGLE = 2'h0;
   localparam logic [1:0] MODE_CONT_SINGLE = 2'h1;
   localparam logic [1:0] MODE_ONE_SCAN = 2'h2;
   localparam logic [1:0] MODE_CONT_SCAN = 2'h3;
   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} aps_adc_state_type;
endpackage

//--- dv/aps_analog_model.sv
// Purpose: far-side model of the analog macros: ADC clock ticks and conversion data
// Assumes: tick_div of 2 or more; data depends on the selected channel
// Notes: data is inverted outside conversion so a stale sample cannot pass
`timescale 1ns/1ps
`default_nettype none
module aps_analog_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] tick_div,
   input wire logic [11:0] data_base,
   input wire logic [3:0] adc_channel,
   input wire logic adc_converting,
   output logic adc_tick,
   output logic [11:0] adc_data
);
   logic [3:0] cnt_reg;
   logic [11:0] val;
   // free-running ADC clock, divided down from pclk
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 4'h0;
         adc_tick <= 1'b0;
      end else if (cnt_reg >= tick_div - 4'h1) begin
         cnt_reg <= 4'h0;
         adc_tick <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 4'h1;
         adc_tick <= 1'b0;
      end
   end
   assign val = data_base ^ {8'h00, adc_channel};
   assign adc_data = adc_converting ? val : ~val;
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Purpose: self-checking bench for the analog power and clock sequencer
// Assumes: ce held high, all byte lanes written
// Notes: APB read expectations queue up and a monitor compares them at pready
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, adc_tick, adc_sampling, adc_converting;
   logic slow_rc_run, fast_rc_powerdown, bandgap_powerdown, ref_measure_enable, pll_powerup, adc_enable;
   logic adc_channel_gain_select, temp_sensor_powerup, dac_powerup, dac_pin_output_enable, dac_full_scale_select;
   logic [1:0] adc_clock_select, adc_bias_current_select, amp_powerup, amp_feedback_ratio, amp_output_route_select;
   logic [1:0] comparator_powerup, comparator_hysteresis_select;
   logic [5:0] comparator_plus_source;
   logic [3:0] comparator_minus_source, adc_channel, trig_events, tick_div, sf, last, sc, e;
   logic [11:0] paddr, adc_data, data_base;
   logic [12:0] p;
   logic [25:0] cfg;
   logic [31:0] pwdata, prdata, rng;
   logic [32:0] exp_q[$];
   logic [32:0] e_m;
   logic [3:0] chs[$];
   logic [15:0] gain;
   int fails = 0, cmp_count = 0, s_cnt = 0, c_cnt = 0, exp_samp = 4, cyc = 0, n;
   aps_sequencer i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .adc_tick(adc_tick), .adc_data(adc_data), .trig_events(trig_events),
      .slow_rc_run(slow_rc_run), .fast_rc_powerdown(fast_rc_powerdown), .bandgap_powerdown(bandgap_powerdown),
      .ref_measure_enable(ref_measure_enable), .pll_powerup(pll_powerup), .adc_clock_select(adc_clock_select),
      .adc_bias_current_select(adc_bias_current_select), .adc_enable(adc_enable), .adc_sampling(adc_sampling),
      .adc_converting(adc_converting), .adc_channel(adc_channel), .adc_channel_gain_select(adc_channel_gain_select),
      .amp_powerup(amp_powerup), .amp_feedback_ratio(amp_feedback_ratio),
      .amp_output_route_select(amp_output_route_select), .comparator_powerup(comparator_powerup),
      .comparator_hysteresis_select(comparator_hysteresis_select), .comparator_plus_source(comparator_plus_source),
      .comparator_minus_source(comparator_minus_source), .temp_sensor_powerup(temp_sensor_powerup),
      .dac_powerup(dac_powerup), .dac_pin_output_enable(dac_pin_output_enable),
      .dac_full_scale_select(dac_full_scale_select));
   aps_analog_model i_model (.pclk(pclk), .presetn(presetn), .tick_div(tick_div), .data_base(data_base),
      .adc_channel(adc_channel), .adc_converting(adc_converting), .adc_tick(adc_tick), .adc_data(adc_data));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      cmp_count++;
      if (got !== ex) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // one transfer; returns at the following falling edge so outputs have settled
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] ex);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      exp_q.push_back(ex);
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask
   task automatic pulse(input int l);
      @(posedge pclk);
      trig_events <= 4'h1 << l;
      @(posedge pclk);
      trig_events <= 4'h0;
   endtask
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fails++;
         summarize();
      end
   end
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
         e_m = exp_q.pop_front();
         chk("pslverr", {31'h0, e_m[32]}, {31'h0, pslverr});
         if (!pwrite) chk("prdata", e_m[31:0], prdata);
      end
      if (adc_tick && adc_sampling) s_cnt++;
      if (adc_tick && adc_converting) begin
         c_cnt++;
         if (c_cnt == 12) begin
            chk("sample ticks", exp_samp, s_cnt);
            chk("gain pin", {31'h0, gain[adc_channel]}, {31'h0, adc_channel_gain_select});
            chs.push_back(adc_channel);
            s_cnt = 0;
            c_cnt = 0;
         end
      end
   end
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, trig_events} = '0;
      tick_div = 4'h2;
      data_base = 12'h000;
      gain = 16'h0000;
      rng = 32'h0000_4875;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk("reset pins", 32'h0000_0400, {21'h0, slow_rc_run, fast_rc_powerdown, bandgap_powerdown, pll_powerup,
         adc_enable, amp_powerup, comparator_powerup, temp_sensor_powerup, dac_powerup});
      apb(1'b0, aps_pkg::OFS_POWER, 32'h0, 33'h0);
      apb(1'b0, aps_pkg::OFS_ADC_CFG, 32'h0, 33'h0);
      apb(1'b0, aps_pkg::OFS_ANALOG, 32'h0, 33'h0);
      for (int i = 0; i < 4; i++) begin
         rng = xs(rng);
         // bandgap kept on, adc kept off while the other users are switched; the last pass powers down fast rc and bandgap
         p = (i == 3) ? 13'h0003 : (rng[12:0] & 13'h1fdd);
         apb(1'b1, aps_pkg::OFS_POWER, {19'h0, p}, 33'h0);
         apb(1'b0, aps_pkg::OFS_POWER, 32'h0, {20'h0, p});
         chk("power pins", {19'h0, p}, {19'h0, dac_full_scale_select, dac_pin_output_enable, dac_powerup,
            comparator_powerup, amp_powerup, adc_enable, temp_sensor_powerup, ref_measure_enable, pll_powerup,
            bandgap_powerdown, fast_rc_powerdown});
         apb(1'b1, aps_pkg::OFS_ANALOG, rng, 33'h0);
         apb(1'b0, aps_pkg::OFS_ANALOG, 32'h0, {17'h0, rng[15:0]});
         chk("analog pins", {16'h0, rng[15:0]}, {16'h0, comparator_minus_source[3:2], comparator_plus_source[5:3],
            comparator_hysteresis_select[1], comparator_minus_source[1:0], comparator_plus_source[2:0],
            comparator_hysteresis_select[0], amp_output_route_select, amp_feedback_ratio});
      end
      apb(1'b0, 12'h020, 32'h0, {1'b1, 32'h0});
      apb(1'b1, 12'h020, 32'hffff_ffff, {1'b1, 32'h0});
      apb(1'b1, aps_pkg::OFS_STATUS, 32'hffff_ffff, 33'h0);
      apb(1'b0, aps_pkg::OFS_POWER, 32'h0, 33'h0_0000_0003);
      // bandgap first; fast rc, pll and temperature sensor once it has settled
      apb(1'b1, aps_pkg::OFS_POWER, 32'h0000_0001, 33'h0);
      repeat (aps_pkg::BG_SETTLE_CYC) @(posedge pclk);
      apb(1'b1, aps_pkg::OFS_POWER, 32'h0000_0014, 33'h0);
      repeat (aps_pkg::PLL_SETTLE_CYC) @(posedge pclk);
      apb(1'b0, aps_pkg::OFS_STATUS, 32'h0, 33'h0_0000_0007);
      apb(1'b1, aps_pkg::OFS_POWER, 32'h0000_0034, 33'h0);
      gain = rng[31:16];
      apb(1'b1, aps_pkg::OFS_GAIN, {16'h0, gain}, 33'h0);
      for (int m = 0; m < 4; m++) begin
         rng = xs(rng);
         data_base <= rng[11:0];
         tick_div <= (m > 1) ? 4'h5 : 4'h2;
         sf = (m == 1) ? 4'h6 : (m == 3) ? 4'h8 : 4'h0;
         last = {2'b00, rng[13:12]};
         sc = rng[19:16];
         exp_samp = sf + 4;
         cfg = {rng[25:24], 4'h0, 2'b00, 2'b00, sc, last, m[1:0], sf, rng[1:0]};
         n = (m == 0) ? 1 : (m == 1) ? 3 : (m == 2) ? last + 1 : last + 2;
         chs.delete();
         s_cnt = 0;
         c_cnt = 0;
         apb(1'b1, aps_pkg::OFS_ADC_CFG, {6'h0, cfg}, 33'h0);
         chk("adc clock pins", {28'h0, cfg[25:24], cfg[1:0]}, {28'h0, adc_bias_current_select, adc_clock_select});
         apb(1'b1, aps_pkg::OFS_CTRL, 32'h0000_0001, 33'h0);
         while (chs.size() < n) @(posedge pclk);
         if (m[0]) apb(1'b1, aps_pkg::OFS_CTRL, 32'h0000_0002, 33'h0);
         while (adc_sampling !== 1'b0 || adc_converting !== 1'b0) @(posedge pclk);
         for (int k = 0; k < n; k++) begin
            e = (m < 2) ? sc : (k > last) ? 4'h0 : k[3:0];
            chk("channel order", {28'h0, e}, {28'h0, chs[k]});
            apb(1'b0, aps_pkg::OFS_RESULT + {6'h0, e, 2'b00}, 32'h0, {21'h0, data_base ^ {8'h00, e}});
         end
      end
      for (int t = 0; t < 4; t++) begin
         chs.delete();
         s_cnt = 0;
         c_cnt = 0;
         exp_samp = 4;
         cfg = {2'b00, 4'h2, 1'b0, 1'b1, t[1:0], 4'h9, 4'h0, 2'b00, 4'h0, 2'b00};
         apb(1'b1, aps_pkg::OFS_ADC_CFG, {6'h0, cfg}, 33'h0);
         pulse((t + 1) % 4);
         pulse(t);
         repeat (4) @(posedge pclk);
         chk("early start", 32'h0, {31'h0, adc_sampling | adc_converting});
         pulse(t);
         while (chs.size() < 1) @(posedge pclk);
         chk("trigger channel", 32'h0000_0009, {28'h0, chs[0]});
      end
      summarize();
   end
endmodule
`default_nettype wire
